//--- synth_clock_ctrl.sv
module synth_clock_ctrl #(
  parameter int SWITCH_CYCLES = synth_clock_pkg::SWITCH_CYC,
  parameter int CNT_W         = 8
) (
  input  wire logic                        mclk_i,
  input  wire logic                        arst_n_i,
  input  wire synth_clock_pkg::apb_req_t   apb_req_i,
  output      synth_clock_pkg::apb_rsp_t   apb_rsp_o,
  input  wire logic                        synth_supply_i,
  input  wire logic                        special_mode_i,
  input  wire logic                        test_mode_i,
  input  wire logic                        wait_exec_i,
  input  wire logic                        irq_any_i,
  input  wire logic                        receiver_active_flag_i,
  input  wire logic                        serial_receiver_enable_i,
  output      synth_clock_pkg::clk_ctl_t   clk_ctl_o
);

  // refuse counter widths that cannot hold the switch time
  if (SWITCH_CYCLES < 1 || SWITCH_CYCLES >= (1 << CNT_W)) begin : g_bad_cnt
    $error("switch cycle count does not fit the counter");
  end

  // a wider counter than this only wastes flops
  if (CNT_W < 1 || CNT_W > 16) begin : g_wide_cnt
    $error("switch counter width out of range");
  end

  // the tap field must sit in the top two bits of the byte
  if (synth_clock_pkg::TAP_LSB + 2 != 8) begin : g_bad_tap
    $error("tap field must occupy the top two bits");
  end

  // the modulus field must fill every bit below the tap
  if (synth_clock_pkg::MOD_W != synth_clock_pkg::TAP_LSB) begin : g_bad_mod
    $error("modulus field must fill the bits below the tap");
  end

  // the strap counter is only two bits wide
  if (synth_clock_pkg::SYNC_SETTLE < 1 || synth_clock_pkg::SYNC_SETTLE > 3) begin : g_bad_settle
    $error("settle count does not fit the strap counter");
  end

  // power and bus select field positions must stay inside the byte lane
  if (synth_clock_pkg::POWER_BIT > 7 || synth_clock_pkg::BUS_SEL_BIT > 7) begin : g_bad_ctrl
    $error("control field position outside the data byte");
  end

  // state layout notes:
  // sup_sync, spec_sync, test_sync - three-flop pin synchronisers
  // settle_cnt, strap_done         - one-shot capture of the supply strap
  // *_lvl                          - debounced pin levels
  // power_en .. wait_en            - software-visible control bits
  // idle                           - synthesizer parked at modulus 1
  // mult                           - tap and modulus byte
  // bus_sel_eff, sw_cnt            - bus clock source after the switch delay
  // rsp, ctl                       - registered outputs

  typedef struct packed {
    logic [2:0]       sup_sync;
    logic [2:0]       spec_sync;
    logic [2:0]       test_sync;
    logic [1:0]       settle_cnt;
    logic             strap_done;
    logic             supply_lvl;
    logic             special_lvl;
    logic             test_lvl;
    logic             power_en;
    logic             bus_sel;
    logic             auto_bw;
    logic             wide_bw;
    logic             loop_test;
    logic             module_sel;
    logic             wait_en;
    logic             idle;
    logic [7:0]       mult;
    logic             bus_sel_eff;
    logic [CNT_W-1:0] sw_cnt;
    synth_clock_pkg::apb_rsp_t rsp;
    synth_clock_pkg::clk_ctl_t ctl;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       setup_phase;
  logic       access_done;
  logic       hit_ctrl;
  logic       hit_mult;
  logic       wr_lane0;
  logic [7:0] wbyte;
  logic [7:0] ctrl_view;
  logic       resume;
  logic       wait_entry;
  logic [5:0] mod_eff;
  logic [1:0] tap_eff;
  logic       power_clear_refused;
  logic       bus_set_refused;
  logic       mult_write_ok;
  logic       loop_write_ok;
  logic       unmapped;

  // apb decode: only the low byte lane carries register data
  assign setup_phase = apb_req_i.psel & ~apb_req_i.penable;
  assign access_done = apb_req_i.psel & apb_req_i.penable & st_r.rsp.pready;
  assign hit_ctrl    = (apb_req_i.paddr == synth_clock_pkg::CTRL_ADDR);
  assign hit_mult    = (apb_req_i.paddr == synth_clock_pkg::MULT_ADDR);
  assign wr_lane0    = access_done & apb_req_i.pwrite & apb_req_i.pstrb[0];
  assign wbyte       = apb_req_i.pwdata[7:0];

  assign ctrl_view = {st_r.power_en, st_r.bus_sel, st_r.auto_bw, st_r.wide_bw,
                      st_r.loop_test, st_r.module_sel, 1'b0, st_r.wait_en};

  assign resume     = irq_any_i | (receiver_active_flag_i & serial_receiver_enable_i);
  assign wait_entry = wait_exec_i & st_r.wait_en;

  // idle runs at modulus 1 (field zero)
  assign mod_eff = st_r.idle ? synth_clock_pkg::IDLE_MODULUS
                             : st_r.mult[synth_clock_pkg::MOD_W-1:0];
  assign tap_eff = st_r.mult[7:synth_clock_pkg::TAP_LSB];

  // write guards, judged on the register state before the write
  // clearing power refused while the bus runs from the synthesizer
  assign power_clear_refused = st_r.bus_sel & ~wbyte[synth_clock_pkg::POWER_BIT];

  // selecting the synthesizer refused while it is still off
  assign bus_set_refused = wbyte[synth_clock_pkg::BUS_SEL_BIT] & ~st_r.power_en;

  // the ratio can only move while the loop is powered down
  assign mult_write_ok = wr_lane0 & hit_mult & ~st_r.power_en;

  // loop test bit only writable in bootstrap or test mode
  assign loop_write_ok = wr_lane0 & hit_ctrl & st_r.special_lvl;

  // unmapped offsets answer with an error and change nothing
  assign unmapped = ~(hit_ctrl | hit_mult);

  // next-state notes:
  // - pin synchronisers run every cycle, before anything reads their levels
  // - the supply strap is caught once after reset and never again
  // - register writes land only at the edge that completes the access
  // - refused bits keep their value; the rest of the byte still lands
  // - wait entry wins over a write or a wake request in the same cycle
  // - the bus clock source follows the select only after the switch delay
  // - every output is taken from the registered state, one cycle later
  // hazard: the switch counter restarts if the select flips back mid-count,
  //   so a quick toggle never glitches the effective source
  // limitation: the switch delay is a fixed cycle count, not a measure of
  //   the real reference and synthesizer edges

  // next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;

    // pin inputs pass three flops; a change counts when stages two and three agree
    st_nxt.sup_sync  = {st_r.sup_sync[1:0], synth_supply_i};
    st_nxt.spec_sync = {st_r.spec_sync[1:0], special_mode_i};
    st_nxt.test_sync = {st_r.test_sync[1:0], test_mode_i};
    if (st_r.sup_sync[2] == st_r.sup_sync[1]) begin
      st_nxt.supply_lvl = st_r.sup_sync[2];
    end
    if (st_r.spec_sync[2] == st_r.spec_sync[1]) begin
      st_nxt.special_lvl = st_r.spec_sync[2];
    end
    if (st_r.test_sync[2] == st_r.test_sync[1]) begin
      st_nxt.test_lvl = st_r.test_sync[2];
    end

    if (!st_r.strap_done) begin
      if (st_r.settle_cnt == 2'(synth_clock_pkg::SYNC_SETTLE)) begin
        st_nxt.strap_done = 1'b1;
        // the debounced level settles in this same cycle, so use its next value
        st_nxt.power_en   = st_nxt.supply_lvl;
      end else begin
        st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
      end
    end

    // register writes, taken only at the completing access edge
    if (wr_lane0 && hit_ctrl) begin
      if (!power_clear_refused) begin
        st_nxt.power_en = wbyte[synth_clock_pkg::POWER_BIT];
      end
      if (!bus_set_refused) begin
        st_nxt.bus_sel = wbyte[synth_clock_pkg::BUS_SEL_BIT];
      end
      st_nxt.auto_bw    = wbyte[synth_clock_pkg::AUTO_BW_BIT];
      st_nxt.wide_bw    = wbyte[synth_clock_pkg::WIDE_BIT];
      st_nxt.module_sel = wbyte[synth_clock_pkg::MODULE_SEL_BIT];
      st_nxt.wait_en    = wbyte[synth_clock_pkg::WAIT_EN_BIT];
    end

    if (loop_write_ok) begin
      st_nxt.loop_test = wbyte[synth_clock_pkg::LOOP_TEST_BIT];
    end

    if (mult_write_ok) begin
      st_nxt.mult = wbyte;
    end

    if (!st_r.special_lvl) begin
      st_nxt.loop_test = 1'b1;
    end

    // wait entry overrides a write in the same cycle
    if (wait_entry) begin
      st_nxt.bus_sel = 1'b0;
      st_nxt.wide_bw = 1'b1;
      st_nxt.idle    = 1'b1;
    end else if (resume) begin
      st_nxt.idle = 1'b0;
    end

    if (st_r.bus_sel != st_r.bus_sel_eff) begin
      if (st_r.sw_cnt == CNT_W'(SWITCH_CYCLES - 1)) begin
        st_nxt.bus_sel_eff = st_r.bus_sel;
        st_nxt.sw_cnt      = '0;
      end else begin
        st_nxt.sw_cnt = st_r.sw_cnt + CNT_W'(1);
      end
    end else begin
      st_nxt.sw_cnt = '0;
    end

    // apb answer: no wait state, pready high in the first access cycle, data captured in setup
    st_nxt.rsp.pready = 1'b0;
    if (setup_phase && !st_r.rsp.pready) begin
      st_nxt.rsp.pready  = 1'b1;
      st_nxt.rsp.pslverr = unmapped;
      st_nxt.rsp.prdata  = 32'h0000_0000;
      if (!apb_req_i.pwrite && hit_ctrl) begin
        st_nxt.rsp.prdata = {24'h00_0000, ctrl_view};
      end else if (!apb_req_i.pwrite && hit_mult) begin
        st_nxt.rsp.prdata = {24'h00_0000, st_r.mult};
      end
    end else if (access_done) begin
      st_nxt.rsp.pslverr = 1'b0;
    end

    st_nxt.ctl.synth_power_enable = st_r.power_en;
    st_nxt.ctl.quad_from_synth    = st_r.bus_sel_eff;
    st_nxt.ctl.module_from_quad   = st_r.module_sel;
    st_nxt.ctl.auto_bw_active     = st_r.auto_bw & st_r.test_lvl;
    st_nxt.ctl.high_bw_driver     = (st_r.auto_bw & st_r.test_lvl) ? 1'b0 : st_r.wide_bw;
    st_nxt.ctl.low_bw_filter      = st_r.loop_test;
    st_nxt.ctl.synth_idle         = st_r.idle;
    st_nxt.ctl.binary_tap_field   = tap_eff;
    st_nxt.ctl.loop_modulus_field = mod_eff;
    // half factor is (modulus+1) shifted by tap
    st_nxt.ctl.mult_factor_half   = 10'({4'h0, mod_eff} + 10'h001) << tap_eff;
  end

  // single state register; reset values are constants only
  // the strap capture waits for the synchronisers, so power enable
  // reads zero for the first few cycles after reset is released
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r           <= '0;
      st_r.auto_bw   <= synth_clock_pkg::AUTO_BW_RESET;
      st_r.wide_bw   <= synth_clock_pkg::WIDE_RESET;
      st_r.loop_test <= synth_clock_pkg::LOOP_RESET;
      st_r.mult      <= synth_clock_pkg::MULT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops, no logic after them
  assign apb_rsp_o = st_r.rsp;
  assign clk_ctl_o = st_r.ctl;

  // usage notes:
  // - enable the synthesizer and select it in two separate writes
  // - a multiplier write while powered is dropped without an error
  // - only byte lane 0 carries register data; other lanes are ignored
  // - the answer always comes one cycle after setup, no extra wait states
  // - idle shows modulus field zero, i.e. the loop runs at modulus 1

endmodule : synth_clock_ctrl

//--- synth_clock_pkg.sv
// Function
// - at reset, power enable follows the synthesizer supply level
// - power enable starts the synthesizer without routing it to clocks
// - power enable cannot be cleared while the bus clock uses the synthesizer
// - bus clock select cannot be set while the synthesizer is off
// - bus select 1 feeds synthesizer to quad clock, 0 crystal; reset clears
// - clock switch completes within 1.5 reference plus 1.5 synthesizer cycles
// - auto bandwidth bit picks auto or manual filter, test mode only; reset sets
// - wide bit adds high bandwidth driver only in manual mode; reset sets
// - loop test bit writable only in bootstrap/test, forced set in user modes
// - module select 1 feeds quad clock to divider chain, 0 crystal; reset clears
// - control register bit 1 is unimplemented and reads zero
// - low-power wait clears bus select, idles at modulus 1, selects wide
// - interrupt, reset or receiver activity resumes the programmed frequency
// - multiplier is 2 times (modulus plus 1) times 2 to the tap
// - multiplier register holds tap in top two bits, modulus in low six
// - multiplier register always readable, writable only with synthesizer off
// - multiplier register resets to a fixed value, 01 by default
package synth_clock_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  CTRL_IDX       = 8'h2E;
  localparam logic [7:0]  MULT_IDX       = 8'h2F;
  localparam logic [11:0] CTRL_ADDR      = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] MULT_ADDR      = {2'h0, MULT_IDX, 2'h0};

  // control register field positions
  localparam int          POWER_BIT      = 7;
  localparam int          BUS_SEL_BIT    = 6;
  localparam int          AUTO_BW_BIT    = 5;
  localparam int          WIDE_BIT       = 4;
  localparam int          LOOP_TEST_BIT  = 3;
  localparam int          MODULE_SEL_BIT = 2;
  localparam int          WAIT_EN_BIT    = 0;

  // multiplier register fields
  localparam int          TAP_LSB        = 6;
  localparam int          MOD_W          = 6;

  // values after reset
  localparam logic [7:0]  MULT_RESET     = 8'h01;
  localparam logic        AUTO_BW_RESET  = 1'b1;
  localparam logic        WIDE_RESET     = 1'b1;
  localparam logic        LOOP_RESET     = 1'b1;
  localparam logic [5:0]  IDLE_MODULUS   = 6'h00;

  // switch time: 1.5 reference plus 1.5 synthesizer periods, in ns
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          REF_PERIOD_NS  = 250;
  localparam int          VCO_PERIOD_NS  = 125;
  localparam int          SWITCH_NS      = (3 * REF_PERIOD_NS + 3 * VCO_PERIOD_NS) / 2;
  localparam int          SWITCH_CYC_RAW = SWITCH_NS / CLK_PERIOD_NS;
  localparam int          SWITCH_CYC     = (SWITCH_CYC_RAW < 1) ? 1 : SWITCH_CYC_RAW;
  localparam int          SYNC_SETTLE    = 3;

  // apb request/answer groups
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // clock steering results
  typedef struct packed {
    logic       synth_power_enable;
    logic       quad_from_synth;
    logic       module_from_quad;
    logic       auto_bw_active;
    logic       high_bw_driver;
    logic       low_bw_filter;
    logic       synth_idle;
    logic [1:0] binary_tap_field;
    logic [5:0] loop_modulus_field;
    logic [9:0] mult_factor_half;
  } clk_ctl_t;

endpackage : synth_clock_pkg

//--- synth_clock_ctrl_asserts.sv
module synth_clock_ctrl_asserts #(
  parameter int SWITCH_CYCLES = synth_clock_pkg::SWITCH_CYC,
  parameter int CNT_W         = 8
) (
  input wire logic                      mclk_i,
  input wire logic                      arst_n_i,
  input wire synth_clock_pkg::apb_req_t apb_req_i,
  input wire synth_clock_pkg::apb_rsp_t apb_rsp_o,
  input wire logic                      wait_exec_i,
  input wire logic                      irq_any_i,
  input wire synth_clock_pkg::clk_ctl_t clk_ctl_o
);
  // one domain, so one clock and one reset guard for all checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  property p_bit1;
    apb_rsp_o.pready && !apb_req_i.pwrite && apb_req_i.paddr == synth_clock_pkg::CTRL_ADDR
      |-> apb_rsp_o.prdata[1] == 1'b0 && apb_rsp_o.prdata[31:8] == 24'h0;
  endproperty
  a_bit1: assert property (p_bit1) else $error("ctrl bit 1 read nonzero");
  // tap can only move after a write that landed with the synthesizer off
  property p_tap_guard;
    $changed(clk_ctl_o.binary_tap_field) |-> !$past(clk_ctl_o.synth_power_enable);
  endproperty
  a_tap_guard: assert property (p_tap_guard) else $error("multiplier changed while on");
  property p_sel_needs_power;
    $rose(clk_ctl_o.quad_from_synth) |-> clk_ctl_o.synth_power_enable;
  endproperty
  a_sel_needs_power: assert property (p_sel_needs_power) else $error("synth clock while off");
  property p_power_no_route;
    $rose(clk_ctl_o.synth_power_enable) |-> !clk_ctl_o.quad_from_synth;
  endproperty
  a_power_no_route: assert property (p_power_no_route) else $error("power on routed clock");
  property p_resume;
    clk_ctl_o.synth_idle && irq_any_i && !wait_exec_i |-> ##2 !clk_ctl_o.synth_idle;
  endproperty
  a_resume: assert property (p_resume) else $error("idle kept after interrupt");
  property p_idle_entry;
    $rose(clk_ctl_o.synth_idle) |-> $past(wait_exec_i, 2)
      && clk_ctl_o.loop_modulus_field == synth_clock_pkg::IDLE_MODULUS;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");
  property p_factor;
    $past(arst_n_i, 2) |-> clk_ctl_o.mult_factor_half
      == ({4'h0, clk_ctl_o.loop_modulus_field} + 10'h001) << clk_ctl_o.binary_tap_field;
  endproperty
  a_factor: assert property (p_factor) else $error("multiplier factor wrong");
  property p_rst_bus;
    $rose(arst_n_i) |-> !clk_ctl_o.quad_from_synth [*3];
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus select not cleared");
  property p_rst_mod;
    $rose(arst_n_i) |-> ##2 !clk_ctl_o.module_from_quad;
  endproperty
  a_rst_mod: assert property (p_rst_mod) else $error("module select not cleared");
  property p_hbw;
    clk_ctl_o.high_bw_driver |-> !clk_ctl_o.auto_bw_active;
  endproperty
  a_hbw: assert property (p_hbw) else $error("high driver in auto mode");

  c_idle: cover property (clk_ctl_o.synth_idle);
  c_switch: cover property ($rose(clk_ctl_o.quad_from_synth));
  c_unmapped: cover property (apb_rsp_o.pready && apb_rsp_o.pslverr);
endmodule : synth_clock_ctrl_asserts

bind synth_clock_ctrl synth_clock_ctrl_asserts #(.SWITCH_CYCLES(SWITCH_CYCLES), .CNT_W(CNT_W))
  u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
         .wait_exec_i(wait_exec_i), .irq_any_i(irq_any_i), .clk_ctl_o(clk_ctl_o));

//--- test_pll_clock_select_control.sv
module test_pll_clock_select_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SW = 2;
  localparam logic [11:0] CA = synth_clock_pkg::CTRL_ADDR;
  localparam logic [11:0] MA = synth_clock_pkg::MULT_ADDR;
  logic mclk_i, arst_n_i, supply, special, tmode, wait_exec, irq, receiver_active_flag, re;
  synth_clock_pkg::apb_req_t req;
  synth_clock_pkg::apb_rsp_t rsp;
  synth_clock_pkg::clk_ctl_t ctl;
  logic [32:0] q[$];
  logic [32:0] note;
  logic [7:0]  r;
  int          err_count, samples_checked, seed, n;

  synth_clock_ctrl #(.SWITCH_CYCLES(SW)) u_synth_clock_ctrl (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .synth_supply_i(supply), .special_mode_i(special), .test_mode_i(tmode),
    .wait_exec_i(wait_exec), .irq_any_i(irq), .receiver_active_flag_i(receiver_active_flag),
    .serial_receiver_enable_i(re), .clk_ctl_o(ctl));

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // one apb transfer; a read leaves its expected {pslverr, prdata} in the queue
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [32:0] e);
    @(posedge mclk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}, pstrb: 4'hF};
    if (!wr) q.push_back(e);
    @(posedge mclk_i);
    req.penable <= 1'b1;
    do @(posedge mclk_i); while (rsp.pready !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask : cyc

  // read monitor: compares each answer against the oldest note
  always @(posedge mclk_i) begin
    if (rsp.pready === 1'b1 && !req.pwrite && q.size() > 0) begin
      note = q.pop_front();
      chk("prdata", note[31:0], rsp.prdata);
      chk("pslverr", {31'h0, note[32]}, {31'h0, rsp.pslverr});
    end
  end

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    cyc(3000);
    err_count++;
    conclude();
  end

  initial begin
    {arst_n_i, special, tmode, wait_exec, irq, receiver_active_flag, re} = '0;
    supply = 1'b1;
    req    = '0;
    seed   = 85;
    cyc(20);
    arst_n_i <= 1'b1;
    cyc(10);
    // power follows supply; reset values of both registers
    apb(0, CA, 8'h00, {1'b0, 32'hB8});
    apb(0, MA, 8'h00, {1'b0, 32'h01});
    apb(1, MA, 8'h55, '0);
    apb(0, MA, 8'h00, {1'b0, 32'h01});
    $display("test reset done");
    apb(1, CA, 8'h38, '0);
    apb(1, CA, 8'h7C, '0);
    apb(0, CA, 8'h00, {1'b0, 32'h3C});
    r = 8'($random(seed));
    apb(1, MA, r, '0);
    apb(0, MA, 8'h00, {1'b0, 24'h0, r});
    chk("factor", 32'((int'(r[5:0]) + 1) << r[7:6]), 32'(ctl.mult_factor_half));
    $display("test guards done");
    apb(1, CA, 8'hBC, '0);
    // power on, settle, then select the fast clock
    cyc(8);
    apb(1, CA, 8'hFC, '0);
    n = 0;
    while (ctl.quad_from_synth !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("switch", 32'h1, 32'(n <= SW + 3));
    chk("module", 32'h1, 32'(ctl.module_from_quad));
    apb(1, CA, 8'h3C, '0);
    apb(0, CA, 8'h00, {1'b0, 32'hBC});
    $display("test switch done");
    apb(1, CA, 8'hFD, '0);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i) wait_exec <= 1'b1;
      @(posedge mclk_i) wait_exec <= 1'b0;
      cyc(3);
      chk("idle", 32'h1, 32'(ctl.synth_idle));
      chk("modulus", 32'h0, 32'(ctl.loop_modulus_field));
      apb(0, CA, 8'h00, {1'b0, 32'hBD});
      receiver_active_flag <= 1'b1;
      cyc(4);
      chk("idle", {31'h0, i == 0}, 32'(ctl.synth_idle));
      {irq, re} <= 2'b11;
      cyc(4);
      chk("resume", 32'h0, 32'(ctl.synth_idle));
      chk("modulus", 32'(r[5:0]), 32'(ctl.loop_modulus_field));
      {irq, receiver_active_flag} <= 2'b00;
      re <= (i == 0);
    end
    // settle after resume before reselecting the synthesizer
    cyc(8);
    apb(1, CA, 8'hFD, '0);
    $display("test wait done");
    apb(0, 12'h000, 8'h00, {1'b1, 32'h0});
    special <= 1'b1;
    cyc(6);
    apb(1, CA, 8'hB5, '0);
    apb(0, CA, 8'h00, {1'b0, 32'hB5});
    tmode <= 1'b1;
    cyc(6);
    chk("auto", 32'h1, 32'(ctl.auto_bw_active));
    chk("hbw", 32'h0, 32'(ctl.high_bw_driver));
    chk("lowbw", 32'h0, 32'(ctl.low_bw_filter));
    // loop settled long ago, narrow is allowed
    apb(1, CA, 8'h85, '0);
    cyc(2);
    chk("auto", 32'h0, 32'(ctl.auto_bw_active));
    chk("hbw", 32'h0, 32'(ctl.high_bw_driver));
    apb(1, CA, 8'h95, '0);
    cyc(2);
    chk("hbw", 32'h1, 32'(ctl.high_bw_driver));
    tmode   <= 1'b0;
    special <= 1'b0;
    cyc(6);
    apb(0, CA, 8'h00, {1'b0, 32'h9D});
    cyc(4);
    $display("test modes done");
    conclude();
  end
endmodule : test_pll_clock_select_control
